// ==== rtl/lcd_host_bus_interface.sv ====
`timescale 1ns/100ps
// What this block does
// - Interface strap picks parallel or serial link
// - Serial link is write only
// - Family strap picks enable or separate strobes
// - Select and direction decode data, status, command
// - Active only with low and high selects
// - Otherwise bus released, controls ignored
// - Serial bit taken on clock rise, MSB first
// - Eighth rising edge forms the byte
// - Select sampled at eighth edge marks type
// - Deselect clears shifter and bit counter
// - Display reads lag one through the bus holder
// - Writes posted, up to four queued for the core
// - Enable style: direction high read, low write
// - Separate style: write latched on strobe rise
// - Separate style: drive bus while read low

`include "lcd_host_defines.svh"

module lcd_write_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset_n,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             do_push;
   logic             do_pop;

   assign in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign do_push   = in_valid & in_ready;
   assign do_pop    = out_valid & out_ready;
   assign out_data  = mem_ff[rd_ptr_ff];

   always_ff @(posedge clock) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_ff <= '0;
      end else if (do_push) begin
         wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_ptr_ff <= '0;
      end else if (do_pop) begin
         rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= '0;
      end else if (do_push & !do_pop) begin
         count_ff <= count_ff + 1'b1;
      end else if (do_pop & !do_push) begin
         count_ff <= count_ff - 1'b1;
      end
   end

endmodule

module lcd_host_bus_interface
   import lcd_host_pkg::*;
(
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               reset_n,
   // Straps
   input  wire logic               interface_select,
   input  wire logic               bus_family_select,
   // Host control pins
   input  wire logic               chip_select_low_n,
   input  wire logic               chip_select_high,
   input  wire logic               data_command_select,
   input  wire logic               read_n_or_enable,
   input  wire logic               write_n_or_direction,
   // Host data pins
   input  wire logic [`BYTE_W-1:0] data_in,
   output logic [`BYTE_W-1:0]      data_out,
   output logic                    data_oe,
   // Posted writes toward the core
   output logic                    cmd_valid,
   input  wire logic               cmd_ready,
   output logic [`BYTE_W-1:0]      cmd_data,
   output logic                    cmd_is_display,
   output logic                    host_write_ready,
   // Display RAM read port
   output logic                    ram_read_req,
   input  wire logic               ram_read_valid,
   input  wire logic [`BYTE_W-1:0] ram_read_data,
   // Status byte from the core
   input  wire logic [`BYTE_W-1:0] status_byte
);

   logic [`SYN_W-1:0]     pins;
   logic [`SYN_W-1:0]     sync1_ff;
   logic [`SYN_W-1:0]     sync2_ff;
   logic                  rd_e_prev_ff;
   logic                  wr_rw_prev_ff;
   logic                  scl_prev_ff;
   logic                  selected;
   logic                  dc_s;
   logic                  rd_e_s;
   logic                  wr_rw_s;
   logic                  si_s;
   logic                  scl_s;
   logic [`BYTE_W-1:0]    bus_s;
   mode_t                 mode;
   logic                  rd_e_rise;
   logic                  rd_e_fall;
   logic                  wr_rise;
   logic                  scl_rise;
   logic [`BYTE_W-1:0]    shift_ff;
   logic [`BIT_CNT_W-1:0] bit_cnt_ff;
   logic                  push;
   logic [`BYTE_W-1:0]    push_byte;
   logic                  read_start;
   logic                  read_end;
   logic                  nxt_oe;
   logic [`BYTE_W-1:0]    holder_ff;
   logic [`BYTE_W-1:0]    data_out_ff;
   logic                  data_oe_ff;
   logic                  ram_read_req_ff;
   logic [`FIFO_W-1:0]    fifo_out;
   logic [2:0]            settle_ff;
   logic                  edges_ok;

   // Pin synchroniser
   assign pins = {interface_select, bus_family_select, chip_select_low_n,
                  chip_select_high, data_command_select, read_n_or_enable,
                  write_n_or_direction, data_in};

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pins;
         sync2_ff <= sync1_ff;
      end
   end

   assign dc_s    = sync2_ff[`SYN_DC];
   assign rd_e_s  = sync2_ff[`SYN_RD_E];
   assign wr_rw_s = sync2_ff[`SYN_WR_RW];
   assign bus_s   = sync2_ff[`SYN_DATA_LO +: `BYTE_W];
   assign si_s    = bus_s[`SER_DATA_BIT];
   assign scl_s   = bus_s[`SER_CLK_BIT];

   // Both selects must agree before anything is seen
   assign selected = !sync2_ff[`SYN_CSL_N] & sync2_ff[`SYN_CSH];

   // Link style from the straps
   always_comb begin
      if (!sync2_ff[`SYN_IFSEL]) begin
         mode = MODE_SERIAL;
      end else if (sync2_ff[`SYN_FAMILY]) begin
         mode = MODE_ENABLE;
      end else begin
         mode = MODE_SEPARATE;
      end
   end

   // Edge history of the strobes and serial clock
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_e_prev_ff  <= 1'b0;
         wr_rw_prev_ff <= 1'b0;
         scl_prev_ff   <= 1'b0;
      end else begin
         rd_e_prev_ff  <= rd_e_s;
         wr_rw_prev_ff <= wr_rw_s;
         scl_prev_ff   <= scl_s;
      end
   end

   // Edges held off until the history holds real pin levels
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         settle_ff <= `SETTLE_RST;
      end else begin
         settle_ff <= {settle_ff[1:0], 1'h1};
      end
   end

   assign edges_ok = settle_ff[2];

   // Strobe and serial clock edges
   assign rd_e_rise = edges_ok & rd_e_s & !rd_e_prev_ff;
   assign rd_e_fall = edges_ok & !rd_e_s & rd_e_prev_ff;
   assign wr_rise   = edges_ok & wr_rw_s & !wr_rw_prev_ff;
   assign scl_rise  = edges_ok & scl_s & !scl_prev_ff;

   // Serial shifter, cleared whenever not selected in serial mode
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         shift_ff   <= `BYTE_RST;
      end else if (!selected || mode != MODE_SERIAL) begin
         shift_ff   <= `BYTE_RST;
      end else if (scl_rise) begin
         shift_ff   <= {shift_ff[`BYTE_W-2:0], si_s};
      end
   end

   // Bit counter toward the byte boundary
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_ff <= `BIT_CNT_RST;
      end else if (!selected || mode != MODE_SERIAL) begin
         bit_cnt_ff <= `BIT_CNT_RST;
      end else if (scl_rise) begin
         bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
   end

   // Write decode; select level gives data or command
   always_comb begin
      push      = 1'b0;
      push_byte = bus_s;
      unique case (mode)
         MODE_SEPARATE: begin
            push = selected & wr_rise;
         end
         MODE_ENABLE: begin
            push = selected & rd_e_fall & !wr_rw_s;
         end
         MODE_SERIAL: begin
            push      = selected & scl_rise & (bit_cnt_ff == `BIT_LAST);
            push_byte = {shift_ff[`BYTE_W-2:0], si_s};
         end
      endcase
   end

   // Read decode; serial mode has no read path
   always_comb begin
      read_start = 1'b0;
      read_end   = 1'b0;
      nxt_oe     = 1'b0;
      unique case (mode)
         MODE_SEPARATE: begin
            read_start = selected & rd_e_fall;
            read_end   = selected & rd_e_rise;
            nxt_oe     = selected & !rd_e_s;
         end
         MODE_ENABLE: begin
            read_start = selected & rd_e_rise & wr_rw_s;
            read_end   = selected & rd_e_fall & wr_rw_s;
            nxt_oe     = selected & rd_e_s & wr_rw_s;
         end
         MODE_SERIAL: begin
            nxt_oe = 1'b0;
         end
      endcase
   end

   // Bus holder: refilled from RAM after each display read
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         holder_ff <= `BYTE_RST;
      end else if (ram_read_valid) begin
         holder_ff <= ram_read_data;
      end
   end

   // One-cycle fetch after each display read
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ram_read_req_ff <= 1'b0;
      end else begin
         ram_read_req_ff <= read_end & dc_s;
      end
   end

   // Output byte: holder for display data, status otherwise
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         data_out_ff <= `BYTE_RST;
      end else if (read_start) begin
         data_out_ff <= dc_s ? holder_ff : status_byte;
      end
   end

   // Bus released unless selected and reading
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         data_oe_ff <= 1'b0;
      end else begin
         data_oe_ff <= nxt_oe;
      end
   end

   // Posted writes held until the core takes them
   lcd_write_fifo #(
      .WIDTH (`FIFO_W),
      .DEPTH (`FIFO_DEPTH)
   ) u_write_fifo (
      .clock     (clock),
      .reset_n   (reset_n),
      .in_valid  (push),
      .in_ready  (host_write_ready),
      .in_data   ({dc_s, push_byte}),
      .out_valid (cmd_valid),
      .out_ready (cmd_ready),
      .out_data  (fifo_out)
   );

   // Outputs from their registers, FIFO byte and flag through its read mux
   assign cmd_data       = fifo_out[`BYTE_W-1:0];
   assign cmd_is_display = fifo_out[`FIFO_DC_BIT];
   assign data_out       = data_out_ff;
   assign data_oe        = data_oe_ff;
   assign ram_read_req   = ram_read_req_ff;

endmodule

// ==== pkg/lcd_host_defines.svh ====
`ifndef LCD_HOST_DEFINES_SVH
`define LCD_HOST_DEFINES_SVH

// Byte width on the host bus and in the serial shifter
`define BYTE_W          8
// Bit count of the serial shifter, last bit index of a byte
`define BIT_CNT_W       3
`define BIT_LAST        3'h7
// Reset values
`define BYTE_RST        8'h00
`define BIT_CNT_RST     3'h0
`define SETTLE_RST      3'h0
// Pin positions inside the synchroniser vector
`define SYN_W           15
`define SYN_IFSEL       14
`define SYN_FAMILY      13
`define SYN_CSL_N       12
`define SYN_CSH         11
`define SYN_DC          10
`define SYN_RD_E        9
`define SYN_WR_RW       8
`define SYN_DATA_LO     0
// Serial data and serial clock share data lines 7 and 6
`define SER_DATA_BIT    7
`define SER_CLK_BIT     6
// Write FIFO entry: display data flag above the byte
`define FIFO_W          9
`define FIFO_DC_BIT     8
`define FIFO_DEPTH      4

`endif

// ==== pkg/lcd_host_pkg.sv ====
package lcd_host_pkg;

   // Host link style chosen by the two straps
   typedef enum logic [1:0] {
      MODE_SERIAL,
      MODE_SEPARATE,
      MODE_ENABLE
   } mode_t;

endpackage

// ==== tb/lcd_host_bus_interface_assertions.sv ====
`timescale 1ns/100ps
`include "lcd_host_defines.svh"
module lcd_host_bus_interface_assertions (
   // Clock and reset
   input wire logic               clock,
   input wire logic               reset_n,
   // Host pins
   input wire logic               interface_select,
   input wire logic               bus_family_select,
   input wire logic               chip_select_high,
   input wire logic               read_n_or_enable,
   input wire logic               write_n_or_direction,
   // Outputs, and ready from the core
   input wire logic               data_oe,
   input wire logic               ram_read_req,
   input wire logic               cmd_valid,
   input wire logic               cmd_ready,
   input wire logic [`BYTE_W-1:0] cmd_data
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   chk_oe_serial_off: assert property ((!interface_select)[*4] |-> !data_oe)
      else $error("bus driven in serial mode");
   chk_oe_desel: assert property ((!chip_select_high)[*4] |-> !data_oe)
      else $error("bus driven while unselected");
   chk_oe_sep_read: assert property
      ((interface_select && !bus_family_select && read_n_or_enable)[*4] |-> !data_oe)
      else $error("bus driven with read strobe high");
   chk_oe_en_low: assert property
      ((interface_select && bus_family_select && !read_n_or_enable)[*4] |-> !data_oe)
      else $error("bus driven with enable low");
   chk_oe_dir_wr: assert property
      ((interface_select && bus_family_select && !write_n_or_direction)[*4] |-> !data_oe)
      else $error("bus driven with direction write");
   chk_req_pulse: assert property (ram_read_req |=> !ram_read_req)
      else $error("fetch request longer than one cycle");
   chk_post_hold: assert property
      (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
      else $error("posted write lost or changed");
   chk_push_selected: assert property ($rose(cmd_valid) |-> $past(chip_select_high, 3))
      else $error("write taken while unselected");
endmodule

// ==== tb/lcd_host_model.sv ====
`timescale 1ns/100ps
`include "lcd_host_defines.svh"
module lcd_host_model (
   // Clock and device answer
   input  wire logic               clock,
   input  wire logic [`BYTE_W-1:0] data_out,
   input  wire logic               data_oe,
   // Host pins
   output logic                    interface_select,
   output logic                    bus_family_select,
   output logic                    chip_select_low_n,
   output logic                    chip_select_high,
   output logic                    data_command_select,
   output logic                    read_n_or_enable,
   output logic                    write_n_or_direction,
   output logic [`BYTE_W-1:0]      data_in
);
   logic [7:0] hd = 8'h00;
   logic       drv = 1'b0;
   // Released lines show the inverse of the last value
   assign data_in = data_oe ? data_out : (drv ? hd : ~hd);
   initial begin
      interface_select = 1'b1;
      bus_family_select = 1'b0;
      chip_select_low_n = 1'b1;
      chip_select_high = 1'b0;
      data_command_select = 1'b0;
      read_n_or_enable = 1'b1;
      write_n_or_direction = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Unused strobes stay fixed in serial mode
   task automatic mode(input logic p, input logic f);
      interface_select = p;
      bus_family_select = f;
      read_n_or_enable = !f;
      write_n_or_direction = 1'b1;
      cyc(8);
   endtask
   // Strobes held 8 cycles, slower than the device needs
   task automatic xfer(input logic sel, input logic dc, input logic rd,
                       input logic [7:0] d, output logic [7:0] q);
      chip_select_low_n = 1'b0;
      chip_select_high = sel;
      data_command_select = dc;
      hd = d;
      drv = !rd;
      if (bus_family_select) write_n_or_direction = rd;
      cyc(5);
      if (bus_family_select) read_n_or_enable = 1'b1;
      else if (rd) read_n_or_enable = 1'b0;
      else write_n_or_direction = 1'b0;
      cyc(8);
      q = data_in;
      read_n_or_enable = !bus_family_select;
      if (!bus_family_select) write_n_or_direction = 1'b1;
      cyc(5);
      chip_select_low_n = 1'b1;
      chip_select_high = 1'b0;
      drv = 1'b0;
      cyc(4);
   endtask
   // Serial clock stands low between frames, 160 ns period inside
   task automatic ser(input logic dc, input logic [7:0] d, input int n);
      drv = 1'b1;
      hd[6] = 1'b0;
      chip_select_low_n = 1'b0;
      chip_select_high = 1'b1;
      data_command_select = dc;
      cyc(4);
      for (int i = 7; i > 7 - n; i--) begin
         hd[7] = d[i];
         cyc(8);
         hd[6] = 1'b1;
         cyc(8);
         hd[6] = 1'b0;
      end
      cyc(4);
      chip_select_low_n = 1'b1;
      chip_select_high = 1'b0;
      cyc(4);
   endtask
endmodule

// ==== tb/lcd_host_bus_interface_tb.sv ====
`timescale 1ns/100ps
module lcd_host_bus_interface_tb;
   logic       clock = 1'b0;
   logic       reset_n = 1'b0;
   logic       interface_select, bus_family_select, chip_select_low_n, chip_select_high;
   logic       data_command_select, read_n_or_enable, write_n_or_direction, data_oe;
   logic       cmd_valid, cmd_is_display, host_write_ready, ram_read_req;
   logic       cmd_ready = 1'b0;
   logic       ram_read_valid = 1'b0;
   logic [7:0] data_in, data_out, cmd_data, exp_hold;
   logic [7:0] ram_read_data = 8'h00;
   logic [7:0] status_byte = 8'h00;
   int         seed = 32'hBD1E46D7;
   int         num_errors = 0;
   int         total_checks = 0;
   int         cycles = 0;
   lcd_host_bus_interface lcd_host_bus_interface_i (.*);
   lcd_host_model lcd_host_model_i (.*);
   always #5 clock = ~clock;
   // Core answers each fetch with a fresh byte
   always @(negedge clock) begin
      ram_read_valid <= ram_read_req;
      if (ram_read_req) ram_read_data <= 8'($random(seed));
      if (ram_read_valid) exp_hold <= ram_read_data;
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         summarize;
      end
   end
   task automatic chk8(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk1(input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic pop(input logic dc, input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_valid !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      chk8(d, cmd_data);
      chk1(dc, cmd_is_display);
      cmd_ready = 1'b1;
      @(negedge clock);
      cmd_ready = 1'b0;
      @(negedge clock);
   endtask
   task automatic summarize;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      logic [7:0] a, b, q, h;
      repeat (6) @(posedge clock);
      @(negedge clock);
      reset_n = 1'b1;
      lcd_host_model_i.cyc(4);
      for (int f = 0; f < 2; f++) begin
         lcd_host_model_i.mode(1'b1, f[0]);
         a = 8'($random(seed));
         b = 8'($random(seed));
         status_byte = 8'($random(seed));
         lcd_host_model_i.xfer(1'b1, 1'b0, 1'b0, a, q);
         lcd_host_model_i.xfer(1'b1, 1'b1, 1'b0, b, q);
         pop(1'b0, a);
         pop(1'b1, b);
         lcd_host_model_i.xfer(1'b1, 1'b1, 1'b1, 8'h00, q);
         h = exp_hold;
         lcd_host_model_i.xfer(1'b1, 1'b1, 1'b1, 8'h00, q);
         chk8(h, q);
         lcd_host_model_i.xfer(1'b1, 1'b0, 1'b1, 8'h00, q);
         chk8(status_byte, q);
         lcd_host_model_i.xfer(1'b0, 1'b1, 1'b0, a, q);
         chk1(1'b0, cmd_valid);
         $display("test parallel %0d done", f);
      end
      for (int i = 0; i < 5; i++) lcd_host_model_i.xfer(1'b1, 1'b1, 1'b0, 8'h10 + i[7:0], q);
      chk1(1'b0, host_write_ready);
      for (int i = 0; i < 4; i++) pop(1'b1, 8'h10 + i[7:0]);
      chk1(1'b0, cmd_valid);
      $display("test fifo done");
      lcd_host_model_i.mode(1'b0, 1'b1);
      a = 8'($random(seed));
      lcd_host_model_i.ser(1'b1, a, 5);
      lcd_host_model_i.ser(1'b0, ~a, 8);
      pop(1'b0, ~a);
      lcd_host_model_i.ser(1'b1, a, 8);
      pop(1'b1, a);
      $display("test serial done");
      summarize;
   end
endmodule
bind lcd_host_bus_interface lcd_host_bus_interface_assertions lcd_host_bus_interface_assertions_i (
   .clock                (clock),
   .reset_n              (reset_n),
   .interface_select     (interface_select),
   .bus_family_select    (bus_family_select),
   .chip_select_high     (chip_select_high),
   .read_n_or_enable     (read_n_or_enable),
   .write_n_or_direction (write_n_or_direction),
   .data_oe              (data_oe),
   .ram_read_req         (ram_read_req),
   .cmd_valid            (cmd_valid),
   .cmd_ready            (cmd_ready),
   .cmd_data             (cmd_data)
);
